// file: design/exec_regs.vh
// register offsets, field positions and reset values of the execution unit
`ifndef EXEC_REGS_VH
`define EXEC_REGS_VH

// register word indices; byte address is four times the index
`define R_CTRL 4'h0
`define R_STATUS 4'h1
`define R_ACCUM 4'h2
`define R_DATA 4'h3
`define R_DEST 4'h4
`define R_EXSEG 4'h5
`define R_FLAGS 4'h6
`define R_OPERAND 4'h7
`define R_REPCNT 4'h8

// control register fields
`define CTL_OP_HI 1
`define CTL_OP_LO 0
`define CTL_WORD 2
`define CTL_PORT_DX 3
`define CTL_REPEAT 4
`define CTL_INC_MEM 5
`define CTL_GO 7

// operation codes
`define OP_MUL 2'h0
`define OP_IN 2'h1
`define OP_INC 2'h2
`define OP_STR 2'h3

// status fields
`define ST_BUSY 0
`define ST_STRING 1

// flag bit positions
`define F_CF 0
`define F_PF 2
`define F_AF 4
`define F_ZF 6
`define F_SF 7
`define F_TF 8
`define F_IF 9
`define F_DF 10
`define F_OF 11

// reset values
`define RST_WORD 16'h0000
`define RST_FLAGS 16'h0000
`define RST_CTRL 8'h00

`endif

// file: design/xfer_fifo.v
// first-in first-out buffer between port reads and memory writes
`timescale 1ns/10ps
module xfer_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire full;
  wire empty;
  wire push;
  wire pop;

  // extra pointer bit tells full from empty
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = store[rd_q[AW-1:0]];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  always @(posedge clock) begin
    if (push) begin
      store[wr_q[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule // xfer_fifo

// file: design/signed_mul_inc_port_input_exec.v
// execution unit for signed multiply, port input, increment, string input
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "exec_regs.vh"
module signed_mul_inc_port_input_exec #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // avalon-mm slave
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  // i/o port read channel
  output reg io_req,
  output reg [15:0] io_addr,
  output reg io_word,
  input wire io_ack,
  input wire [15:0] io_rdata,
  // memory channel
  output reg mem_req,
  output reg mem_we,
  output reg mem_word,
  output reg [19:0] mem_addr,
  output reg [15:0] mem_wdata,
  input wire mem_ack,
  input wire [15:0] mem_rdata
);

  localparam S_IDLE = 3'h0;
  localparam S_IN = 3'h1;
  localparam S_MRD = 3'h2;
  localparam S_MWR = 3'h3;
  localparam S_STR = 3'h4;

  // architectural state
  reg [15:0] acc_q, dxr_q, di_q, es_q, flags_q, opnd_q, rcnt_q;
  reg [7:0] ctrl_q;
  reg [2:0] state_q;
  reg [15:0] tmp_q, prod_left_q, cons_left_q;
  reg io_rel_q, mem_rel_q;
  // pin synchronisers
  reg io_ack_s1, io_ack_s2, mem_ack_s1, mem_ack_s2;
  reg [15:0] io_dat_s1, io_dat_s2, mem_dat_s1, mem_dat_s2;
  reg [31:0] rd_d;
  wire idle, bus_take, go, ctl_word, ctl_rep;
  wire fifo_in_ready, fifo_out_valid, fifo_push, fifo_pop;
  wire [15:0] fifo_out_data, push_data, inc_acc, inc_mem, di_step;
  wire signed [15:0] prod_b;
  wire signed [31:0] prod_w;
  wire ovf_b, ovf_w;

  // segment base shifted by four plus offset, fixed to the extra segment
  function [19:0] phys;
    input [15:0] seg, off;
    begin
      phys = {seg, 4'h0} + {4'h0, off};
    end
  endfunction

  // byte lanes of a bus write applied to a 16-bit register
  function [15:0] merge;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // add one, byte form keeps the high byte untouched
  function [15:0] incr;
    input [15:0] v;
    input w;
    reg [7:0] lo;
    begin
      lo = v[7:0] + 8'h01;
      incr = w ? v + 16'h0001 : {v[15:8], lo};
    end
  endfunction

  // flags after an increment; carry and control flags pass through
  function [15:0] inc_flags;
    input [15:0] fl, r;
    input w;
    reg [15:0] f;
    begin
      f = fl;
      f[`F_AF] = (r[3:0] == 4'h0);
      f[`F_OF] = w ? (r == 16'h8000) : (r[7:0] == 8'h80);
      f[`F_SF] = w ? r[15] : r[7];
      f[`F_ZF] = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
      inc_flags = f;
    end
  endfunction

  assign idle = (state_q == S_IDLE) && !io_rel_q && !mem_rel_q;
  assign bus_take = (read || write) && waitrequest;
  assign go = bus_take && write && idle && (address[5:2] == `R_CTRL) &&
    byteenable[0] && writedata[`CTL_GO];
  assign ctl_word = ctrl_q[`CTL_WORD];
  assign ctl_rep = ctrl_q[`CTL_REPEAT];

  assign prod_b = $signed(opnd_q[7:0]) * $signed(acc_q[7:0]);
  assign prod_w = $signed(opnd_q) * $signed(acc_q);
  assign ovf_b = (prod_b[15:8] != {8{prod_b[7]}});
  assign ovf_w = (prod_w[31:16] != {16{prod_w[15]}});
  assign inc_acc = incr(acc_q, writedata[`CTL_WORD]);
  assign inc_mem = incr(mem_dat_s2, ctl_word);

  // word transfers step by two, byte transfers by one
  assign di_step = ctl_word ? 16'h0002 : 16'h0001;
  assign push_data = ctl_word ? io_dat_s2 : {8'h00, io_dat_s2[7:0]};
  assign fifo_push = (state_q == S_STR) && io_req && io_ack_s2;
  assign fifo_pop = (state_q == S_STR) && (cons_left_q != 16'h0000) &&
    !mem_req && !mem_rel_q && fifo_out_valid;

  // the buffer lets port reads run ahead of slow memory writes
  xfer_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  always @* begin
    rd_d = 32'h0000_0000;
    case (address[5:2])
      `R_CTRL: rd_d = {24'h00_0000, ctrl_q};
      `R_STATUS: rd_d = {30'h0000_0000, state_q == S_STR, !idle};
      `R_ACCUM: rd_d = {16'h0000, acc_q};
      `R_DATA: rd_d = {16'h0000, dxr_q};
      `R_DEST: rd_d = {16'h0000, di_q};
      `R_EXSEG: rd_d = {16'h0000, es_q};
      `R_FLAGS: rd_d = {16'h0000, flags_q};
      `R_OPERAND: rd_d = {16'h0000, opnd_q};
      `R_REPCNT: rd_d = {16'h0000, rcnt_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
      waitrequest <= 1'b1;
      io_req <= 1'b0;
      io_addr <= `RST_WORD;
      io_word <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_word <= 1'b0;
      mem_addr <= 20'h0_0000;
      mem_wdata <= `RST_WORD;
      acc_q <= `RST_WORD;
      dxr_q <= `RST_WORD;
      di_q <= `RST_WORD;
      es_q <= `RST_WORD;
      flags_q <= `RST_FLAGS;
      opnd_q <= `RST_WORD;
      rcnt_q <= `RST_WORD;
      ctrl_q <= `RST_CTRL;
      state_q <= S_IDLE;
      tmp_q <= `RST_WORD;
      prod_left_q <= `RST_WORD;
      cons_left_q <= `RST_WORD;
      io_rel_q <= 1'b0;
      mem_rel_q <= 1'b0;
      io_ack_s1 <= 1'b0;
      io_ack_s2 <= 1'b0;
      io_dat_s1 <= `RST_WORD;
      io_dat_s2 <= `RST_WORD;
      mem_ack_s1 <= 1'b0;
      mem_ack_s2 <= 1'b0;
      mem_dat_s1 <= `RST_WORD;
      mem_dat_s2 <= `RST_WORD;
    end else begin
      // data must be stable at the pins before ack rises
      io_ack_s1 <= io_ack;
      io_ack_s2 <= io_ack_s1;
      io_dat_s1 <= io_rdata;
      io_dat_s2 <= io_dat_s1;
      mem_ack_s1 <= mem_ack;
      mem_ack_s2 <= mem_ack_s1;
      mem_dat_s1 <= mem_rdata;
      mem_dat_s2 <= mem_dat_s1;

      // one answer per request; writes while busy are dropped
      waitrequest <= 1'b1;
      if (bus_take) begin
        waitrequest <= 1'b0;
        if (read) begin
          readdata <= rd_d;
        end
        if (write && idle) begin
          case (address[5:2])
            `R_ACCUM: acc_q <= merge(acc_q, writedata, byteenable);
            `R_DATA: dxr_q <= merge(dxr_q, writedata, byteenable);
            `R_DEST: di_q <= merge(di_q, writedata, byteenable);
            `R_EXSEG: es_q <= merge(es_q, writedata, byteenable);
            `R_FLAGS: flags_q <= merge(flags_q, writedata, byteenable);
            `R_OPERAND: opnd_q <= merge(opnd_q, writedata, byteenable);
            `R_REPCNT: rcnt_q <= merge(rcnt_q, writedata, byteenable);
            default: ;
          endcase
        end
      end

      // four-phase release: wait for ack low before the next request
      if (io_rel_q && !io_ack_s2) begin
        io_rel_q <= 1'b0;
      end
      if (mem_rel_q && !mem_ack_s2) begin
        mem_rel_q <= 1'b0;
      end

      case (state_q)
        S_IDLE: begin
          if (go) begin
            ctrl_q <= writedata[7:0];
            case (writedata[`CTL_OP_HI:`CTL_OP_LO])
              `OP_MUL: begin
                if (writedata[`CTL_WORD]) begin
                  dxr_q <= prod_w[31:16];
                  acc_q <= prod_w[15:0];
                  flags_q[`F_CF] <= ovf_w;
                  flags_q[`F_OF] <= ovf_w;
                end else begin
                  acc_q <= prod_b;
                  flags_q[`F_CF] <= ovf_b;
                  flags_q[`F_OF] <= ovf_b;
                end
              end
              `OP_IN: begin
                io_req <= 1'b1;
                io_word <= writedata[`CTL_WORD];
                if (writedata[`CTL_PORT_DX]) begin
                  io_addr <= dxr_q;
                end else begin
                  io_addr <= {8'h00, opnd_q[7:0]};
                end
                state_q <= S_IN;
              end
              `OP_INC: begin
                if (writedata[`CTL_INC_MEM]) begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_word <= writedata[`CTL_WORD];
                  mem_addr <= phys(es_q, opnd_q);
                  state_q <= S_MRD;
                end else begin
                  acc_q <= inc_acc;
                  flags_q <= inc_flags(flags_q, inc_acc,
                    writedata[`CTL_WORD]);
                end
              end
              default: begin
                // one transfer, or as many as the repeat count holds
                if (writedata[`CTL_REPEAT]) begin
                  prod_left_q <= rcnt_q;
                  cons_left_q <= rcnt_q;
                end else begin
                  prod_left_q <= 16'h0001;
                  cons_left_q <= 16'h0001;
                end
                state_q <= S_STR;
              end
            endcase
          end
        end
        S_IN: begin
          if (io_req && io_ack_s2) begin
            io_req <= 1'b0;
            io_rel_q <= 1'b1;
            if (io_word) begin
              acc_q <= io_dat_s2;
            end else begin
              acc_q[7:0] <= io_dat_s2[7:0];
            end
            state_q <= S_IDLE;
          end
        end
        S_MRD: begin
          if (mem_req && mem_ack_s2) begin
            mem_req <= 1'b0;
            mem_rel_q <= 1'b1;
            tmp_q <= inc_mem;
            flags_q <= inc_flags(flags_q, inc_mem, ctl_word);
            state_q <= S_MWR;
          end
        end
        S_MWR: begin
          if (!mem_req && !mem_rel_q) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_wdata <= tmp_q;
          end else if (mem_req && mem_ack_s2) begin
            mem_req <= 1'b0;
            mem_rel_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_STR: begin
          // producer: a read is only issued when the buffer has room
          if ((prod_left_q != 16'h0000) && !io_req && !io_rel_q &&
              fifo_in_ready) begin
            io_req <= 1'b1;
            io_word <= ctl_word;
            io_addr <= dxr_q;
            prod_left_q <= prod_left_q - 16'h0001;
          end else if (io_req && io_ack_s2) begin
            io_req <= 1'b0;
            io_rel_q <= 1'b1;
          end
          // consumer: memory write at the extra segment, no override
          if (fifo_pop) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_word <= ctl_word;
            mem_addr <= phys(es_q, di_q);
            mem_wdata <= fifo_out_data;
          end else if (mem_req && mem_ack_s2) begin
            mem_req <= 1'b0;
            mem_rel_q <= 1'b1;
            cons_left_q <= cons_left_q - 16'h0001;
            if (ctl_rep) begin
              rcnt_q <= rcnt_q - 16'h0001;
            end
            if (flags_q[`F_DF]) begin
              di_q <= di_q - di_step;
            end else begin
              di_q <= di_q + di_step;
            end
          end else if ((cons_left_q == 16'h0000) && !mem_req) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule // signed_mul_inc_port_input_exec

// file: dv/port_mem_model.sv
// port and memory responder on the far side of the execution unit
`timescale 1ns/10ps
module port_mem_model (
  // clock and reset
  input wire clock,
  input wire rst,
  // port channel
  input wire io_req,
  input wire [15:0] io_addr,
  input wire io_word,
  output reg io_ack,
  output reg [15:0] io_rdata,
  // memory channel, hold stalls the answer
  input wire mem_req,
  input wire mem_we,
  input wire mem_word,
  input wire [19:0] mem_addr,
  input wire [15:0] mem_wdata,
  input wire hold,
  output reg mem_ack,
  output reg [15:0] mem_rdata
);
  reg [15:0] mem [0:255];
  reg [15:0] io_last;
  reg io_wlast;
  reg io_stg;
  reg mem_stg;
  integer io_n;
  integer wr_n;
  wire [7:0] a = mem_addr[7:0];
  // data settles a cycle before ack so both sync stages agree
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      io_ack <= 1'b0;
      io_stg <= 1'b0;
      io_rdata <= 16'h0000;
      io_n <= 0;
    end else if (io_req && !io_ack) begin
      io_rdata <= io_addr ^ 16'ha5c3;
      io_stg <= 1'b1;
      io_ack <= io_stg;
      io_last <= io_addr;
      io_wlast <= io_word;
      if (io_stg)
        io_n <= io_n + 1;
    end else if (!io_req && io_ack) begin
      io_ack <= 1'b0;
      io_stg <= 1'b0;
      // released lines show no stale value
      io_rdata <= ~io_rdata;
    end
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      mem_stg <= 1'b0;
      mem_rdata <= 16'h0000;
      wr_n <= 0;
    end else if (mem_req && !mem_ack && !hold) begin
      mem_rdata <= mem[a];
      mem_stg <= 1'b1;
      mem_ack <= mem_stg;
      if (mem_stg && mem_we) begin
        mem[a] <= mem_word ? mem_wdata : {mem[a][15:8], mem_wdata[7:0]};
        wr_n <= wr_n + 1;
      end
    end else if (!mem_req && mem_ack) begin
      mem_ack <= 1'b0;
      mem_stg <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // port_mem_model

// file: dv/exec_assertions.sv
// bus, port and memory protocol checks for the execution unit
`timescale 1ns/10ps
module exec_assertions (
  // clock and reset
  input wire clock,
  input wire rst,
  // register bus
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  // port channel
  input wire io_req,
  input wire [15:0] io_addr,
  input wire io_word,
  input wire io_ack,
  input wire [15:0] io_rdata,
  // memory channel
  input wire mem_req,
  input wire mem_we,
  input wire mem_word,
  input wire [19:0] mem_addr,
  input wire [15:0] mem_wdata,
  input wire mem_ack,
  input wire [15:0] mem_rdata
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered next cycle");
  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  rdata_upper_a: assert property (!waitrequest |-> readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  io_hold_a: assert property (io_req && $past(io_req) |->
    $stable(io_addr) && $stable(io_word)) else $error("port request moved");
  io_drop_a: assert property ($rose(io_ack) |-> ##[1:4] $fell(io_req))
    else $error("port request not released after ack");
  io_restart_a: assert property (io_ack |-> !$rose(io_req))
    else $error("port request raised while ack high");
  mem_hold_a: assert property (mem_req && $past(mem_req) |->
    $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_we))
    else $error("memory request moved");
  mem_drop_a: assert property ($rose(mem_ack) |-> ##[1:4] $fell(mem_req))
    else $error("memory request not released after ack");
  mem_restart_a: assert property (mem_ack |-> !$rose(mem_req))
    else $error("memory request raised while ack high");
  cover property (mem_req && mem_we && mem_ack);
  cover property (io_req && io_word && io_ack);
  cover property (read && !waitrequest);
endmodule // exec_assertions
bind signed_mul_inc_port_input_exec exec_assertions u_chk (
  .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .io_req(io_req), .io_addr(io_addr),
  .io_word(io_word), .io_ack(io_ack), .io_rdata(io_rdata), .mem_req(mem_req),
  .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

// file: dv/signed_mul_inc_port_input_exec_tb.sv
// self-checking bench for the execution unit
`timescale 1ns/10ps
`include "exec_regs.vh"
module signed_mul_inc_port_input_exec_tb;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg [5:0] address = 6'h00;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0000_0000;
  reg [3:0] byteenable = 4'h0;
  reg hold = 1'b0;
  reg [15:0] rv;
  wire [31:0] readdata;
  wire waitrequest, io_req, io_word, io_ack, mem_req, mem_we, mem_word, mem_ack;
  wire [15:0] io_addr, io_rdata, mem_wdata, mem_rdata;
  wire [19:0] mem_addr;
  integer num_errors = 0;
  integer tests_run = 0;
  integer base;
  signed_mul_inc_port_input_exec u_dut (.clock(clock), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .io_req(io_req), .io_addr(io_addr), .io_word(io_word), .io_ack(io_ack),
    .io_rdata(io_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  port_mem_model u_pm (.clock(clock), .rst(rst), .io_req(io_req),
    .io_word(io_word),
    .io_addr(io_addr), .io_ack(io_ack), .io_rdata(io_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .hold(hold),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    forever #20 clock = ~clock;
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // request held until waitrequest is sampled low
  task wr(input [3:0] r, input [15:0] d);
    begin
      @(posedge clock);
      address <= {r, 2'b00};
      writedata <= {16'h0000, d};
      byteenable <= 4'h3;
      write <= 1'b1;
      @(posedge clock);
      while (waitrequest !== 1'b0)
        @(posedge clock);
      write <= 1'b0;
    end
  endtask
  task rd(input [3:0] r);
    begin
      @(posedge clock);
      address <= {r, 2'b00};
      read <= 1'b1;
      @(posedge clock);
      while (waitrequest !== 1'b0)
        @(posedge clock);
      rv = readdata[15:0];
      read <= 1'b0;
    end
  endtask
  task idle;
    begin
      rv = 16'h0001;
      while (rv[0] !== 1'b0)
        rd(`R_STATUS);
    end
  endtask
  task t_map;
    integer i;
    begin
      for (i = 0; i < 9; i = i + 1) begin
        rd(i[3:0]);
        chk("reset", rv, 16'h0000);
      end
      wr(4'h9, 16'hffff);
      rd(4'h9);
      chk("unmapped", rv, 16'h0000);
      wr(`R_STATUS, 16'h0003);
      rd(`R_STATUS);
      chk("status ro", rv, 16'h0000);
      $display("test map done");
    end
  endtask
  task t_mul;
    begin
      wr(`R_FLAGS, 16'h0700);
      wr(`R_ACCUM, 16'h00f0);
      wr(`R_OPERAND, 16'h0010);
      wr(`R_CTRL, 16'h0080);
      rd(`R_ACCUM);
      chk("mul8", rv, 16'hff00);
      rd(`R_FLAGS);
      chk("mul8 fl", rv & 16'h0f01, 16'h0f01);
      wr(`R_ACCUM, 16'hfffe);
      wr(`R_OPERAND, 16'h0003);
      wr(`R_CTRL, 16'h0084);
      rd(`R_ACCUM);
      chk("mul16 lo", rv, 16'hfffa);
      rd(`R_DATA);
      chk("mul16 hi", rv, 16'hffff);
      rd(`R_FLAGS);
      chk("mul16 fl", rv & 16'h0f01, 16'h0700);
      $display("test mul done");
    end
  endtask
  task t_in;
    begin
      wr(`R_FLAGS, 16'h0fd5);
      wr(`R_ACCUM, 16'habcd);
      wr(`R_OPERAND, 16'h1234);
      wr(`R_CTRL, 16'h0081);
      idle;
      rd(`R_ACCUM);
      chk("in8", rv, 16'habf7);
      chk("in8 port", u_pm.io_last, 16'h0034);
      chk("in8 size", u_pm.io_wlast, 1'b0);
      wr(`R_DATA, 16'hffff);
      wr(`R_CTRL, 16'h008d);
      idle;
      rd(`R_ACCUM);
      chk("in16", rv, 16'h5a3c);
      chk("in16 port", u_pm.io_last, 16'hffff);
      chk("in16 size", u_pm.io_wlast, 1'b1);
      rd(`R_FLAGS);
      chk("in fl", rv, 16'h0fd5);
      $display("test in done");
    end
  endtask
  task t_inc;
    begin
      wr(`R_FLAGS, 16'h0f01);
      wr(`R_ACCUM, 16'h12ff);
      wr(`R_CTRL, 16'h0082);
      rd(`R_ACCUM);
      chk("inc8", rv, 16'h1200);
      rd(`R_FLAGS);
      chk("inc8 fl", rv, 16'h0751);
      wr(`R_FLAGS, 16'h0000);
      wr(`R_ACCUM, 16'h7fff);
      wr(`R_CTRL, 16'h0086);
      rd(`R_ACCUM);
      chk("inc16", rv, 16'h8000);
      rd(`R_FLAGS);
      chk("inc16 fl", rv, 16'h0890);
      u_pm.mem[8'h30] = 16'h00fe;
      wr(`R_EXSEG, 16'h0001);
      wr(`R_OPERAND, 16'h0020);
      wr(`R_CTRL, 16'h00a6);
      idle;
      chk("inc mem", u_pm.mem[8'h30], 16'h00ff);
      $display("test inc done");
    end
  endtask
  task t_str;
    begin
      wr(`R_FLAGS, 16'h0000);
      wr(`R_DATA, 16'h0100);
      wr(`R_EXSEG, 16'h0000);
      wr(`R_DEST, 16'h0040);
      wr(`R_REPCNT, 16'h0018);
      base = u_pm.io_n;
      hold <= 1'b1;
      wr(`R_CTRL, 16'h0097);
      // memory stalls: one word waits in the write, sixteen in the buffer
      repeat (400) @(posedge clock);
      chk("fifo full", u_pm.io_n - base, 17);
      base = u_pm.wr_n;
      hold <= 1'b0;
      idle;
      chk("rep count", u_pm.wr_n - base, 24);
      chk("rep data", u_pm.mem[8'h6e], 16'ha4c3);
      rd(`R_DEST);
      chk("rep dest", rv, 16'h0070);
      rd(`R_REPCNT);
      chk("rep cnt", rv, 16'h0000);
      wr(`R_FLAGS, 16'h0400);
      wr(`R_DEST, 16'h0050);
      wr(`R_REPCNT, 16'h0005);
      wr(`R_CTRL, 16'h0083);
      idle;
      chk("one data", u_pm.mem[8'h50][7:0], 8'hc3);
      rd(`R_DEST);
      chk("one dest", rv, 16'h004f);
      rd(`R_REPCNT);
      chk("one cnt", rv, 16'h0005);
      rd(`R_FLAGS);
      chk("str fl", rv, 16'h0400);
      $display("test string done");
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // generous span; the sequence takes well under a tenth of it
  initial begin
    #2000000;
    num_errors = num_errors + 1;
    $display("watchdog expired");
    end_sim;
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_map;
    t_mul;
    t_in;
    t_inc;
    t_str;
    end_sim;
  end
endmodule // signed_mul_inc_port_input_exec_tb
